//--- hdl/uart_ffc_pkg.sv
// Purpose: constants for the uart fifo and flow-control channel
// Assumes: classic wishbone byte registers, word aligned, one clock
package uart_ffc_pkg;
	localparam int FIFO_DEPTH = 16;
	localparam int CNT_W = 5;
	localparam logic [3:0] A_DATA = 4'h0;
	localparam logic [3:0] A_IER = 4'h1;
	localparam logic [3:0] A_FCR = 4'h2;
	localparam logic [3:0] A_LCR = 4'h3;
	localparam logic [3:0] A_MCR = 4'h4;
	localparam logic [3:0] A_LSR = 4'h5;
	localparam logic [3:0] A_X4 = 4'h4;
	localparam logic [3:0] A_X5 = 4'h5;
	localparam logic [3:0] A_X6 = 4'h6;
	localparam logic [3:0] A_X7 = 4'h7;
	localparam logic [7:0] LCR_ENH = 8'hBF;
	localparam int LCR_DLAB = 7;
	localparam int FCR_EN = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int EFR_SPEC = 5;
	localparam int EFR_ARTS = 6;
	localparam int EFR_ACTS = 7;
	localparam int IER_RX = 0;
	localparam int IER_XOFF = 5;
	localparam int IER_RTS = 6;
	localparam int IER_CTS = 7;
	localparam int MCR_IRQEN = 3;
	localparam logic [5:0] ISR_NONE = 6'h01;
	localparam logic [5:0] ISR_RDA = 6'h04;
	localparam logic [5:0] ISR_TMO = 6'h0C;
	localparam logic [5:0] ISR_XOFF = 6'h10;
	localparam logic [5:0] ISR_CTSRTS = 6'h20;
	localparam int TMO_CHARS = 4;
	localparam int BITS_PER_CHAR = 10;
	localparam int TICKS_PER_BIT = 16;
	localparam logic [15:0] TMO_TICKS = 16'(TMO_CHARS * BITS_PER_CHAR * TICKS_PER_BIT);
	localparam logic [3:0] STOP_CENTRE = 4'h8;
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [7:0] ISR_FIFO_BITS = 8'hC0;
	typedef enum logic [1:0] {FS_IDLE, FS_STOP1, FS_STOP2} fc_send_type;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
endpackage

//--- hdl/uart_ffc_fifo.sv
// Purpose: byte fifo with registered read data and occupancy count
// Assumes: push ignored when full, pop ignored when empty
// Notes: head word is always visible on rdata_o
`timescale 1ns/1ps
module uart_ffc_fifo #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	// stream
	input wire logic push_i,
	input wire logic [7:0] wdata_i,
	input wire logic pop_i,
	output logic [7:0] rdata_o,
	output logic [AW:0] count_o
);
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic do_push;
	logic do_pop;
	logic [AW-1:0] rp_nxt;
	assign do_push = push_i && (count_o != (AW+1)'(DEPTH));
	assign do_pop = pop_i && (count_o != '0);
	assign rp_nxt = do_pop ? rp_r + 1'b1 : rp_r;
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem[wp_r] <= wdata_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			wp_r <= '0;
			rp_r <= '0;
			count_o <= '0;
		end else begin
			if (do_push) begin
				wp_r <= wp_r + 1'b1;
			end
			rp_r <= rp_nxt;
			count_o <= count_o + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
	// bypass write into head when empty so read data stays current
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (do_push && (wp_r == rp_nxt)) begin
			rdata_o <= wdata_i;
		end else begin
			rdata_o <= mem[rp_nxt];
		end
	end
endmodule

//--- hdl/uart_ffc.sv
// Purpose: uart channel with fifos, auto rts/cts and xon/xoff control
// Assumes: classic wishbone slave, 8-bit data in low byte of 32-bit word
// Notes: fixed 8-n-1 framing for tx; rx compares use line word length
`timescale 1ns/1ps
module uart_ffc
	import uart_ffc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// serial and modem
	input wire logic rx_i,
	output logic tx_o,
	input wire logic cts_n_i,
	output logic rts_n_o,
	// interrupt
	input wire logic irq_output_select_i,
	output logic irq_o,
	output logic irq_oe_o
);
	import uart_ffc_pkg::*;
	logic [7:0] interrupt_enable_reg, fifo_control_reg, line_control_reg, modem_control_reg;
	logic [7:0] enhanced_feature_reg, divisor_low_byte, divisor_high_byte;
	logic [7:0] resume_char_first, resume_char_second, stop_char_first, stop_char_second;
	logic [CNT_W-1:0] rx_cnt, tx_cnt;
	logic [7:0] rx_head, tx_head;
	logic [3:0] adr;
	logic req, wr, rd, enh_sel, dl_sel;
	logic rx_pop, tx_push, rx_push;
	logic [15:0] div_cnt_r;
	logic tick_r;
	logic [4:0] trig_lvl, trig_hi, trig_lo;
	assign adr = adr_i[5:2];
	assign req = cyc_i && stb_i && !ack_o;
	assign wr = req && we_i && sel_i[0];
	assign rd = req && !we_i;
	assign enh_sel = (line_control_reg == LCR_ENH);
	assign dl_sel = line_control_reg[LCR_DLAB] && !enh_sel;
	assign rx_pop = rd && !line_control_reg[LCR_DLAB] && adr == A_DATA;
	assign tx_push = wr && !line_control_reg[LCR_DLAB] && adr == A_DATA;

	// ==========================================================
	// register file
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			interrupt_enable_reg <= 8'h00;
			fifo_control_reg <= 8'h00;
			line_control_reg <= 8'h00;
			modem_control_reg <= 8'h00;
			enhanced_feature_reg <= 8'h00;
			divisor_low_byte <= 8'h00;
			divisor_high_byte <= 8'h00;
			resume_char_first <= 8'h00;
			resume_char_second <= 8'h00;
			stop_char_first <= 8'h00;
			stop_char_second <= 8'h00;
		end else if (wr) begin
			if (adr == A_LCR) begin
				line_control_reg <= dat_i[7:0];
			end else if (enh_sel) begin
				case (adr)
					A_FCR: enhanced_feature_reg <= dat_i[7:0];
					A_X4: resume_char_first <= dat_i[7:0];
					A_X5: resume_char_second <= dat_i[7:0];
					A_X6: stop_char_first <= dat_i[7:0];
					A_X7: stop_char_second <= dat_i[7:0];
					default: ;
				endcase
			end else if (dl_sel && adr == A_DATA) begin
				divisor_low_byte <= dat_i[7:0];
			end else if (dl_sel && adr == A_IER) begin
				divisor_high_byte <= dat_i[7:0];
			end else if (!line_control_reg[LCR_DLAB]) begin
				case (adr)
					A_IER: interrupt_enable_reg <= dat_i[7:0];
					// fifo enable and rx trigger select
					A_FCR: fifo_control_reg <= {dat_i[7:6], 5'h00, dat_i[FCR_EN]};
					A_MCR: modem_control_reg <= dat_i[7:0];
					default: ;
				endcase
			end
		end
	end
	// fifo reset strobes act once, they are not stored
	logic rx_flush, tx_flush;
	assign rx_flush = wr && !line_control_reg[LCR_DLAB] && adr == A_FCR &&
		(dat_i[FCR_RXRST] || dat_i[FCR_EN] != fifo_control_reg[FCR_EN]);
	assign tx_flush = wr && !line_control_reg[LCR_DLAB] && adr == A_FCR &&
		(dat_i[FCR_TXRST] || dat_i[FCR_EN] != fifo_control_reg[FCR_EN]);

	// ==========================================================
	// baud generator
	// divide by divisor, zero halts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt_r <= 16'h0001;
			tick_r <= 1'b0;
		end else if ({divisor_high_byte, divisor_low_byte} == 16'h0000) begin
			div_cnt_r <= 16'h0001;
			tick_r <= 1'b0;
		end else if (div_cnt_r >= {divisor_high_byte, divisor_low_byte}) begin
			div_cnt_r <= 16'h0001;
			tick_r <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 16'h0001;
			tick_r <= 1'b0;
		end
	end

	// ==========================================================
	// trigger levels 1/4/8/14, next above and below
	always_comb begin
		case (fifo_control_reg[7:6])
			2'b00: begin trig_lvl = 5'd1; trig_hi = 5'd4; trig_lo = 5'd0; end
			2'b01: begin trig_lvl = 5'd4; trig_hi = 5'd8; trig_lo = 5'd1; end
			2'b10: begin trig_lvl = 5'd8; trig_hi = 5'd14; trig_lo = 5'd4; end
			default: begin trig_lvl = 5'd14; trig_hi = 5'd16; trig_lo = 5'd8; end
		endcase
	end
	function automatic logic [7:0] wmask(input logic [1:0] wl);
		wmask = 8'hFF >> (2'd3 - wl);
	endfunction
	logic [7:0] cmask;
	assign cmask = wmask(line_control_reg[1:0]);

	// ==========================================================
	// receiver
	rx_state_type rx_st;
	logic [3:0] rx_ph;
	logic [2:0] rx_bit;
	logic [7:0] rx_sh;
	logic rx_done;
	logic [7:0] rx_char, rx_prev;
	logic prev_stop_m, prev_res_m;
	always_ff @(posedge clk_i) begin
		rx_done <= 1'b0;
		if (rst_i) begin
			rx_st <= RX_IDLE;
			rx_ph <= 4'h0;
			rx_bit <= 3'd0;
			rx_sh <= 8'h00;
		end else if (tick_r) begin
			rx_ph <= rx_ph + 4'h1;
			case (rx_st)
				RX_IDLE: if (!rx_i) begin rx_st <= RX_START; rx_ph <= 4'h1; end
				RX_START: if (rx_ph == STOP_CENTRE - 4'h1) begin
					rx_st <= rx_i ? RX_IDLE : RX_DATA;
					rx_ph <= 4'h0;
					rx_bit <= 3'd0;
				end
				RX_DATA: if (rx_ph == TICK_LAST) begin
					// first received bit lands in bit 0
					rx_sh <= {rx_i, rx_sh[7:1]} ;
					rx_bit <= rx_bit + 3'd1;
					// last data bit index is word length minus one (4..7)
					if (rx_bit == 3'd4 + {1'b0, line_control_reg[1:0]}) begin
						rx_st <= RX_STOP;
					end
				end
				RX_STOP: if (rx_ph == TICK_LAST) begin
					rx_st <= RX_IDLE;
					rx_done <= 1'b1;
				end
				default: rx_st <= RX_IDLE;
			endcase
		end
	end
	assign rx_char = (rx_sh >> (2'd3 - line_control_reg[1:0])) & cmask;
	logic m_s1, m_s2, m_r1, m_r2, dbl, sw_on, stop_hit, res_hit, spec_hit;
	assign m_s1 = (rx_char & cmask) == (stop_char_first & cmask);
	assign m_s2 = (rx_char & cmask) == (stop_char_second & cmask);
	assign m_r1 = (rx_char & cmask) == (resume_char_first & cmask);
	assign m_r2 = (rx_char & cmask) == (resume_char_second & cmask);
	assign dbl = enhanced_feature_reg[1] && enhanced_feature_reg[0];
	assign sw_on = enhanced_feature_reg[1] || enhanced_feature_reg[0];
	assign stop_hit = sw_on && (dbl ? (prev_stop_m && m_s2) : (m_s1 || m_s2));
	assign res_hit = sw_on && (dbl ? (prev_res_m && m_r2) : (m_r1 || m_r2));
	assign spec_hit = enhanced_feature_reg[EFR_SPEC] && m_s2;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_stop_m <= 1'b0;
			prev_res_m <= 1'b0;
		end else if (rx_done) begin
			prev_stop_m <= m_s1;
			prev_res_m <= m_r1;
		end
	end
	// flow chars dropped, in double mode only the second of a pair; accept until full
	logic first_held;
	assign first_held = dbl && ((m_s1 && !prev_stop_m) || (m_r1 && !prev_res_m));
	assign rx_push = rx_done && !(stop_hit || res_hit) && rx_cnt != CNT_W'(FIFO_DEPTH);
	assign rx_prev = first_held ? rx_char : 8'h00;
	uart_ffc_fifo #(.DEPTH(FIFO_DEPTH), .AW(CNT_W-1)) rx_fifo (
		.clk_i(clk_i), .rst_i(rst_i), .flush_i(rx_flush),
		.push_i(rx_push), .wdata_i(rx_char), .pop_i(rx_pop),
		.rdata_o(rx_head), .count_o(rx_cnt));

	// ==========================================================
	// time-out
	// restart at centre of stop bit and on read, expire at 4 chars
	logic [15:0] tmo_r;
	logic tmo_flag_r;
	always_ff @(posedge clk_i) begin
		if (rst_i || rx_pop || rx_cnt == '0 ||
			(tick_r && rx_st == RX_STOP && rx_ph == STOP_CENTRE)) begin
			tmo_r <= 16'h0000;
		end else if (tick_r && tmo_r != TMO_TICKS) begin
			tmo_r <= tmo_r + 16'h0001;
		end
	end
	// time-out only with data below trigger
	always_ff @(posedge clk_i) begin
		if (rst_i || rx_pop || rx_cnt == '0) begin
			tmo_flag_r <= 1'b0;
		end else if (tmo_r == TMO_TICKS && rx_cnt < trig_lvl) begin
			tmo_flag_r <= 1'b1;
		end
	end

	// ==========================================================
	// flow control state
	logic xoff_halt_r, xflag_r, cts_prev_r, cts_flag_r, rts_off_r;
	// halt on stop, resume and clear on resume; set beats clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xoff_halt_r <= 1'b0;
			xflag_r <= 1'b0;
		end else if (rx_done && (stop_hit || spec_hit)) begin
			xoff_halt_r <= stop_hit || xoff_halt_r;
			xflag_r <= 1'b1;
		end else if (rx_done && res_hit) begin
			xoff_halt_r <= 1'b0;
			xflag_r <= 1'b0;
		end
	end
	// cts rising edge flag, cleared by status read
	logic isr_rd;
	assign isr_rd = rd && !line_control_reg[LCR_DLAB] && !enh_sel && adr == A_FCR;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cts_prev_r <= 1'b0;
			cts_flag_r <= 1'b0;
		end else begin
			cts_prev_r <= cts_n_i;
			if (enhanced_feature_reg[EFR_ACTS] && cts_n_i && !cts_prev_r) begin
				cts_flag_r <= 1'b1;
			end else if (isr_rd) begin
				cts_flag_r <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rts_off_r <= 1'b0;
		end else if (!enhanced_feature_reg[EFR_ARTS]) begin
			rts_off_r <= 1'b0;
		end else if (rx_cnt >= trig_hi) begin
			rts_off_r <= 1'b1;
		end else if (rx_cnt <= trig_lo) begin
			rts_off_r <= 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		rts_n_o <= rst_i ? 1'b0 : rts_off_r;
	end

	// ==========================================================
	// transmitter
	tx_state_type tx_st;
	fc_send_type fs_st;
	logic [3:0] tx_ph;
	logic [2:0] tx_bit;
	logic [7:0] tx_sh;
	logic tx_pop, send_stop_r, sent_stop_r, tx_go;
	// send stop chars above trigger, resume chars below
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sent_stop_r <= 1'b0;
		end else if (tx_st == TX_IDLE && fs_st == FS_IDLE && sw_on && tick_r) begin
			if (!sent_stop_r && rx_cnt > trig_lvl) begin
				sent_stop_r <= 1'b1;
			end else if (sent_stop_r && rx_cnt < trig_lvl) begin
				sent_stop_r <= 1'b0;
			end
		end
	end
	assign send_stop_r = sent_stop_r;
	// gating is checked only between characters
	assign tx_go = !(enhanced_feature_reg[EFR_ACTS] && cts_n_i) && !xoff_halt_r;
	assign tx_pop = tick_r && tx_st == TX_IDLE && fs_st == FS_IDLE && tx_go &&
		tx_cnt != '0 && !(sw_on && ((!sent_stop_r && rx_cnt > trig_lvl) ||
		(sent_stop_r && rx_cnt < trig_lvl)));
	uart_ffc_fifo #(.DEPTH(FIFO_DEPTH), .AW(CNT_W-1)) tx_fifo (
		.clk_i(clk_i), .rst_i(rst_i), .flush_i(tx_flush),
		.push_i(tx_push), .wdata_i(dat_i[7:0]), .pop_i(tx_pop),
		.rdata_o(tx_head), .count_o(tx_cnt));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_st <= TX_IDLE;
			fs_st <= FS_IDLE;
			tx_ph <= 4'h0;
			tx_bit <= 3'd0;
			tx_sh <= 8'h00;
			tx_o <= 1'b1;
		end else if (tick_r) begin
			tx_ph <= tx_ph + 4'h1;
			case (tx_st)
				TX_IDLE: begin
					tx_o <= 1'b1;
					tx_ph <= 4'h0;
					if (fs_st == FS_STOP1 && dbl) begin
						tx_sh <= send_stop_r ? stop_char_second : resume_char_second;
						fs_st <= FS_STOP2;
						tx_st <= TX_START;
					end else if (fs_st != FS_IDLE) begin
						fs_st <= FS_IDLE;
					end else if (sw_on && !sent_stop_r && rx_cnt > trig_lvl) begin
						tx_sh <= stop_char_first;
						fs_st <= FS_STOP1;
						tx_st <= TX_START;
					end else if (sw_on && sent_stop_r && rx_cnt < trig_lvl) begin
						tx_sh <= resume_char_first;
						fs_st <= FS_STOP1;
						tx_st <= TX_START;
					end else if (tx_pop) begin
						tx_sh <= tx_head;
						tx_st <= TX_START;
					end
				end
				TX_START: begin
					tx_o <= 1'b0;
					if (tx_ph == TICK_LAST) begin
						tx_st <= TX_DATA;
						tx_bit <= 3'd0;
					end
				end
				TX_DATA: begin
					tx_o <= tx_sh[tx_bit];
					if (tx_ph == TICK_LAST) begin
						tx_bit <= tx_bit + 3'd1;
						if (tx_bit == 3'd7) begin
							tx_st <= TX_STOP;
						end
					end
				end
				TX_STOP: begin
					tx_o <= 1'b1;
					if (tx_ph == TICK_LAST) begin
						tx_st <= TX_IDLE;
					end
				end
				default: tx_st <= TX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// interrupt priority and output
	logic [5:0] isr_code;
	logic rda;
	// data ready at trigger, shares level with time-out
	assign rda = rx_cnt >= trig_lvl;
	always_comb begin
		if (interrupt_enable_reg[IER_RX] && rda) begin
			isr_code = ISR_RDA;
		end else if (interrupt_enable_reg[IER_RX] && tmo_flag_r) begin
			isr_code = ISR_TMO;
		end else if (interrupt_enable_reg[IER_XOFF] && xflag_r) begin
			isr_code = ISR_XOFF;
		end else if ((interrupt_enable_reg[IER_CTS] && cts_flag_r) ||
			(interrupt_enable_reg[IER_RTS] && rts_off_r)) begin
			isr_code = ISR_CTSRTS;
		end else begin
			isr_code = ISR_NONE;
		end
	end
	// select pin decides whether modem bit 3 gates the output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			irq_oe_o <= 1'b0;
		end else begin
			irq_o <= isr_code != ISR_NONE;
			irq_oe_o <= irq_output_select_i || modem_control_reg[MCR_IRQEN];
		end
	end

	// ==========================================================
	// bus answer, registered ack one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= req;
			if (rd) begin
				dat_o <= 32'h0;
				if (adr == A_LCR) dat_o[7:0] <= line_control_reg;
				else if (enh_sel) begin
					case (adr)
						A_FCR: dat_o[7:0] <= enhanced_feature_reg;
						A_X4: dat_o[7:0] <= resume_char_first;
						A_X5: dat_o[7:0] <= resume_char_second;
						A_X6: dat_o[7:0] <= stop_char_first;
						A_X7: dat_o[7:0] <= stop_char_second;
						default: ;
					endcase
				end else if (dl_sel && adr == A_DATA) dat_o[7:0] <= divisor_low_byte;
				else if (dl_sel && adr == A_IER) dat_o[7:0] <= divisor_high_byte;
				else if (!line_control_reg[LCR_DLAB]) begin
					case (adr)
						A_DATA: dat_o[7:0] <= rx_head;
						A_IER: dat_o[7:0] <= interrupt_enable_reg;
						A_FCR: dat_o[7:0] <= {2'b00, isr_code} |
							(fifo_control_reg[FCR_EN] ? ISR_FIFO_BITS : 8'h00);
						A_MCR: dat_o[7:0] <= modem_control_reg;
						A_LSR: dat_o[7:0] <= {1'b0, tx_cnt == '0 && tx_st == TX_IDLE,
							tx_cnt == '0, 4'h0, rx_cnt != '0};
						default: ;
					endcase
				end
			end
		end
	end

	// ==========================================================
	// checks
	AST_RTS_HI: assert property (@(posedge clk_i) disable iff (rst_i)
		enhanced_feature_reg[EFR_ARTS] && rx_cnt >= trig_hi |-> ##2 rts_n_o)
		else $error("rts not raised at upper level");
	AST_RTS_LO: assert property (@(posedge clk_i) disable iff (rst_i)
		!enhanced_feature_reg[EFR_ARTS] |-> ##2 !rts_n_o)
		else $error("rts off without auto rts");
	AST_TMO_EMPTY: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_cnt == '0 |=> !tmo_flag_r)
		else $error("time-out with empty fifo");
	AST_NO_FLOWCHAR: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_done && stop_hit |-> !rx_push)
		else $error("flow char stored");
	AST_XOFF_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
		xoff_halt_r |-> !tx_pop)
		else $error("tx popped while halted");
	AST_CTS_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
		enhanced_feature_reg[EFR_ACTS] && cts_n_i |-> !tx_pop)
		else $error("tx popped while cts off");
	AST_DIV0: assert property (@(posedge clk_i) disable iff (rst_i)
		{divisor_high_byte, divisor_low_byte} == 16'h0000 |=> !tick_r)
		else $error("tick with zero divisor");
	AST_IRQ_OE: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_output_select_i |=> irq_oe_o)
		else $error("irq output not enabled");
	AST_RESUME: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_done && res_hit && !stop_hit && !spec_hit |=> !xflag_r && !xoff_halt_r)
		else $error("resume did not clear");
endmodule

//--- tb/serial_peer.sv
// Purpose: remote serial peer sending and capturing 8-n-1 frames
// Assumes: divisor 1, so one bit lasts 16 clocks
// Notes: line idles high between frames
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT_CLKS = 16
) (
	// clock and serial lines
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o
);
	// ==========
	// frames
	initial line_o = 1'h1;
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			line_o <= f[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
	endtask
	// bounded wait, so a held transmitter shows as no frame
	task automatic recv(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (line_i !== 1'h0 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		ok = (line_i === 1'h0);
		repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			b[i] = line_i;
			repeat (BIT_CLKS) @(posedge clk_i);
		end
	endtask
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench for the uart fifo and flow-control channel
// Assumes: divisor 1, so 16 clocks a bit
// Notes: one task a scenario
`timescale 1ns/1ps
module tb_top;
	import uart_ffc_pkg::*;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc = 1'h0;
	logic we = 1'h0;
	logic cts_n = 1'h0;
	logic isel = 1'h1;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, rx, tx, rts_n, irq, irq_oe, ok;
	logic [7:0] q;
	int failures = 0;
	int comparisons = 0;
	// ==========
	// clock, design and peer
	always #2.5 clk_i = ~clk_i;
	uart_ffc i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .rx_i(rx),
		.tx_o(tx), .cts_n_i(cts_n), .rts_n_o(rts_n), .irq_output_select_i(isel),
		.irq_o(irq), .irq_oe_o(irq_oe));
	serial_peer i_peer (.clk_i(clk_i), .line_i(tx), .line_o(rx));
	// ==========
	// shared tasks
	task automatic compare(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'h1;
		we <= w;
		adr <= {idx, 2'h0};
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'h1 && n < 20);
		if (ack !== 1'h1) begin
			failures++;
			$display("BAD %0t bus answer timed out", $time);
		end
		q = rdat[7:0];
		cyc <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic rc(input logic [3:0] idx, input logic [7:0] exp);
		wb(1'h0, idx, 8'h00);
		compare(q, exp);
	endtask
	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (irq !== 1'h1 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		compare({7'h00, irq}, 8'h01);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_regs();
		wb(1'h1, A_LCR, LCR_ENH);
		for (int i = 4; i < 8; i++)
			rc(4'(i), 8'h00);
		wb(1'h1, A_X6, 8'h13);
		wb(1'h1, A_X4, 8'h11);
		rc(A_X6, 8'h13);
		wb(1'h1, A_LCR, 8'h80);
		wb(1'h1, 4'h0, 8'h01);
		wb(1'h1, 4'h1, 8'h00);
		wb(1'h1, A_LCR, 8'h03);
		rc(A_FCR, 8'h01);
		rc(A_LSR, 8'h60);
		rc(4'h8, 8'h00);
	endtask
	task automatic t_tx_rx();
		wb(1'h1, A_FCR, 8'h01);
		wb(1'h1, A_IER, 8'h01);
		wb(1'h1, A_DATA, 8'h5A);
		i_peer.recv(q, ok);
		compare(q, 8'h5A);
		i_peer.send(8'h3C);
		wait_irq(200);
		rc(A_FCR, 8'hC4);
		rc(A_DATA, 8'h3C);
		rc(A_FCR, 8'hC1);
	endtask
	task automatic t_timeout();
		wb(1'h1, A_FCR, 8'h41);
		i_peer.send(8'hA5);
		repeat (300) @(posedge clk_i);
		compare({7'h00, irq}, 8'h00);
		wait_irq(1500);
		rc(A_FCR, 8'hCC);
		rc(A_DATA, 8'hA5);
		repeat (900) @(posedge clk_i);
		compare({7'h00, irq}, 8'h00);
	endtask
	task automatic t_xoff();
		wb(1'h1, A_LCR, LCR_ENH);
		wb(1'h1, A_FCR, 8'h02);
		wb(1'h1, A_LCR, 8'h03);
		wb(1'h1, A_IER, 8'h21);
		i_peer.send(8'h13);
		repeat (20) @(posedge clk_i);
		rc(A_FCR, 8'hD0);
		rc(A_LSR, 8'h60);
		wb(1'h1, A_DATA, 8'h77);
		i_peer.recv(q, ok);
		compare({7'h00, ok}, 8'h00);
		fork
			i_peer.send(8'h11);
			i_peer.recv(q, ok);
		join
		compare(q, 8'h77);
		rc(A_FCR, 8'hC1);
	endtask
	task automatic t_spec();
		wb(1'h1, A_LCR, LCR_ENH);
		wb(1'h1, A_FCR, 8'h20);
		wb(1'h1, A_X7, 8'h2A);
		wb(1'h1, A_LCR, 8'h03);
		wb(1'h1, A_IER, 8'h20);
		i_peer.send(8'h2A);
		repeat (20) @(posedge clk_i);
		rc(A_FCR, 8'hD0);
		rc(A_DATA, 8'h2A);
	endtask
	task automatic t_rts();
		wb(1'h1, A_LCR, LCR_ENH);
		wb(1'h1, A_FCR, 8'h40);
		wb(1'h1, A_LCR, 8'h03);
		wb(1'h1, A_FCR, 8'h01);
		for (int i = 0; i < 3; i++)
			i_peer.send(8'(8'h41 + i));
		repeat (20) @(posedge clk_i);
		compare({7'h00, rts_n}, 8'h00);
		i_peer.send(8'h44);
		repeat (20) @(posedge clk_i);
		compare({7'h00, rts_n}, 8'h01);
		for (int i = 0; i < 4; i++)
			rc(A_DATA, 8'(8'h41 + i));
		repeat (2) @(posedge clk_i);
		compare({7'h00, rts_n}, 8'h00);
	endtask
	task automatic t_cts_oe();
		wb(1'h1, A_LCR, LCR_ENH);
		wb(1'h1, A_FCR, 8'h80);
		wb(1'h1, A_LCR, 8'h03);
		wb(1'h1, A_IER, 8'h80);
		cts_n <= 1'h1;
		repeat (4) @(posedge clk_i);
		wb(1'h1, A_DATA, 8'h66);
		rc(A_FCR, 8'hE0);
		i_peer.recv(q, ok);
		compare({7'h00, ok}, 8'h00);
		cts_n <= 1'h0;
		i_peer.recv(q, ok);
		compare(q, 8'h66);
		isel <= 1'h0;
		wb(1'h1, A_MCR, 8'h00);
		@(posedge clk_i);
		compare({7'h00, irq_oe}, 8'h00);
		wb(1'h1, A_MCR, 8'h08);
		@(posedge clk_i);
		compare({7'h00, irq_oe}, 8'h01);
	endtask
	// ==========
	// main sequence and watchdog
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		t_regs();
		t_tx_rx();
		t_timeout();
		t_xoff();
		t_spec();
		t_rts();
		t_cts_oe();
		print_verdict();
	end
	initial begin
		#200us;
		failures++;
		print_verdict();
	end
endmodule
